// file: motion_ctl_model.sv
// model of the motion controller driving the drive's digital inputs
`timescale 1ns/1ps
`default_nettype none
module motion_ctl_model (
  input  wire logic       clk,
  output var  logic       torque_position_select,
  output var  logic       command_trigger,
  output var  logic [1:0] torque_cmd_select,
  output var  logic [1:0] speed_cmd_select,
  output var  logic [5:0] position_cmd_select
);
  initial begin
    torque_position_select = 1'b1;
    command_trigger = 1'b0;
    torque_cmd_select = 2'h0;
    speed_cmd_select = 2'h0;
    position_cmd_select = 6'h3F;
  end
  task set_tp(input logic v);
    @(posedge clk);
    torque_position_select <= v;
  endtask
  task set_sel(input logic [1:0] t, input logic [1:0] s);
    @(posedge clk);
    torque_cmd_select <= t;
    speed_cmd_select <= s;
  endtask
  task raise_trig(input logic [5:0] idx);
    @(posedge clk);
    position_cmd_select <= idx;
    repeat (2) @(posedge clk);
    command_trigger <= 1'b1;
  endtask
  task drop_trig;
    @(posedge clk);
    command_trigger <= 1'b0;
  endtask
endmodule // motion_ctl_model
`default_nettype wire

// file: servo_mode_limit_monitor_select.v
// torque/position dual-mode command selection, limits and analog monitor scaling
//
// Contract
// R1: pulse dual mode takes pulses as position; table dual mode takes table entries.
// R2: select input ON gives torque mode, torque select chooses command, trigger ignored.
// R3: select input OFF leaves position undetermined, motor held until trigger rises.
// R4: trigger rise latches six position-select inputs and starts move; controller presets them.
// R5: select input back ON returns to torque mode at once, no trigger needed.
// R6: speed always clamped to the maximum-speed parameter in every mode.
// R7: speed limit source is analog input or one of three speed presets.
// R8: speed limit only in torque mode and with its enable bit set.
// R9: torque limit source is analog input or one of three torque presets.
// R10: torque limit only in position or speed mode with its enable bit set.
// R11: monitor source holds two hex digits, ch1 upper, range 00-77, reset 01.
// R12: digit codes: speed, torque, pulse freq, speed cmd, torque cmd, bus volts, reserved.
// R13: output code is quantity over full scale times eight volts times proportion/100.
// R14: polarity digit: 0 none, 1 ch2, 2 ch1, 3 both inverted.
// R15: pulse output polarity digit 0 forward, 1 reverse, shared by all pulse outputs.
// R16: each channel has a proportion 0-100 percent, reset 100.
// R17: control-mode code 07 selects pulse-train position / torque dual mode.
// R18: control-mode code 09 selects table position / torque dual mode.
// R19: digital inputs synchronised; trigger edge from two synced samples, one event per edge.
// R20: reserved monitor source codes drive the channel code to zero.
//
// The strobed register port was left to the implementer.
`include "servo_select_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module servo_mode_limit_monitor_select #(
  parameter        QW             = 24,
  parameter        PW             = 32,
  parameter        TBL_DEPTH      = 64,
  parameter [23:0] MAX_TORQUE     = 24'h00012C,
  parameter [23:0] MAX_TORQUE_CMD = 24'h00012C
) (
  input  wire                 clk,
  input  wire                 rst_n,
  input  wire [15:0]          reg_addr,
  input  wire [15:0]          reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output wire [15:0]          reg_rdata,
  input  wire                 torque_position_select,
  input  wire                 command_trigger,
  input  wire [1:0]           torque_cmd_select,
  input  wire [1:0]           speed_cmd_select,
  input  wire [5:0]           position_cmd_select,
  input  wire signed [15:0]   analog_speed_in,
  input  wire signed [15:0]   analog_torque_in,
  input  wire [PW-1:0]        pulse_position_in,
  input  wire signed [QW-1:0] motor_speed,
  input  wire signed [QW-1:0] motor_torque,
  input  wire signed [QW-1:0] pulse_frequency,
  input  wire signed [QW-1:0] speed_command,
  input  wire signed [QW-1:0] torque_command,
  input  wire signed [QW-1:0] bus_voltage,
  output wire                 torque_mode,
  output wire                 position_mode,
  output wire                 motor_hold,
  output wire                 move_start,
  output wire [PW-1:0]        position_cmd,
  output wire                 position_from_table,
  output wire signed [15:0]   torque_cmd,
  output wire [15:0]          speed_limit,
  output wire                 speed_limit_active,
  output wire [15:0]          torque_limit,
  output wire                 torque_limit_active,
  output wire                 pulse_reverse,
  output wire signed [9:0]    monitor_channel_one,
  output wire signed [9:0]    monitor_channel_two
);

  // ==========================================================
  // state codes
  localparam [3:0] ST_IDLE   = 4'h1;
  localparam [3:0] ST_TORQUE = 4'h2;
  localparam [3:0] ST_WAIT   = 4'h4;
  localparam [3:0] ST_RUN    = 4'h8;

  // ==========================================================
  // configuration registers
  reg  [6:0]    mon_src_q;
  reg  [4:0]    polarity_q;
  reg  [6:0]    prop1_q;
  reg  [6:0]    prop2_q;
  reg  [7:0]    ctrl_mode_q;
  reg  [1:0]    limit_en_q;
  reg  [15:0]   max_speed_q;
  reg  [15:0]   spd_pre_q [0:2];
  reg  [15:0]   trq_pre_q [0:2];
  reg  [5:0]    tbl_index_q;
  reg  [15:0]   tbl_lo_stage_q;
  reg  [PW-1:0] tbl_mem_q [0:TBL_DEPTH-1];
  reg  [15:0]   rdata_q;
  integer       i;

  wire [6:0] prop_w = (reg_wdata > {9'h000, `PROP_MAX}) ? `PROP_MAX : reg_wdata[6:0];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_src_q      <= `RST_MON_SRC;
      polarity_q     <= `RST_POLARITY;
      prop1_q        <= `RST_PROP;
      prop2_q        <= `RST_PROP;
      ctrl_mode_q    <= `RST_CTRL_MODE;
      limit_en_q     <= `RST_LIMIT_EN;
      max_speed_q    <= `RST_MAX_SPEED;
      tbl_index_q    <= 6'h00;
      tbl_lo_stage_q <= 16'h0000;
      for (i = 0; i < 3; i = i + 1) begin
        spd_pre_q[i] <= 16'h0000;
        trq_pre_q[i] <= 16'h0000;
      end
      for (i = 0; i < TBL_DEPTH; i = i + 1) begin
        tbl_mem_q[i] <= {PW{1'b0}};
      end
    end else if (reg_wr) begin
      case (reg_addr)
        // digits above 7 are cut to three bits, so the field stays in 00-77
        `OFS_MON_SRC:   mon_src_q <= {reg_wdata[6:4], 1'b0, reg_wdata[2:0]}; // R11
        `OFS_POLARITY:  polarity_q <= {reg_wdata[4], 2'h0, reg_wdata[1:0]};
        `OFS_PROP_CH1:  prop1_q <= prop_w; // R16
        `OFS_PROP_CH2:  prop2_q <= prop_w; // R16
        `OFS_CTRL_MODE: ctrl_mode_q <= reg_wdata[7:0];
        `OFS_LIMIT_EN:  limit_en_q <= reg_wdata[1:0];
        `OFS_MAX_SPEED: max_speed_q <= reg_wdata;
        `OFS_SPD_PRE1:  spd_pre_q[0] <= reg_wdata;
        `OFS_SPD_PRE2:  spd_pre_q[1] <= reg_wdata;
        `OFS_SPD_PRE3:  spd_pre_q[2] <= reg_wdata;
        `OFS_TRQ_PRE1:  trq_pre_q[0] <= reg_wdata;
        `OFS_TRQ_PRE2:  trq_pre_q[1] <= reg_wdata;
        `OFS_TRQ_PRE3:  trq_pre_q[2] <= reg_wdata;
        `OFS_TBL_INDEX: tbl_index_q <= reg_wdata[5:0];
        `OFS_TBL_LO:    tbl_lo_stage_q <= reg_wdata;
        // writing the high half commits the whole entry, so a move never sees half an update
        `OFS_TBL_HI:    tbl_mem_q[tbl_index_q] <= {reg_wdata[PW-17:0], tbl_lo_stage_q};
        default:        tbl_index_q <= tbl_index_q;
      endcase
    end
  end

  // ==========================================================
  // input synchroniser and trigger edge
  wire [11:0] di_raw = {torque_position_select, command_trigger, torque_cmd_select,
                        speed_cmd_select, position_cmd_select};
  reg  [11:0] di_s1_q;
  reg  [11:0] di_s2_q;
  reg         trig_prev_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      di_s1_q     <= 12'h000;
      di_s2_q     <= 12'h000;
      trig_prev_q <= 1'b0;
    end else begin
      di_s1_q     <= di_raw; // R19
      di_s2_q     <= di_s1_q; // R19
      trig_prev_q <= di_s2_q[10]; // R19
    end
  end

  wire       tp_on     = di_s2_q[11];
  wire       trig_rise = di_s2_q[10] & ~trig_prev_q; // R19
  wire [1:0] tcm_sel   = di_s2_q[9:8];
  wire [1:0] spd_sel   = di_s2_q[7:6];
  // same depth as the trigger, so inputs set up before the edge are the ones latched
  wire [5:0] pos_sel   = di_s2_q[5:0]; // R4

  // ==========================================================
  // dual-mode state machine
  wire pt_mode = (ctrl_mode_q == `MODE_PT_T); // R17
  wire pr_mode = (ctrl_mode_q == `MODE_PR_T); // R18
  wire dual    = pt_mode | pr_mode;

  reg  [3:0] st_q;
  reg  [3:0] st_d;
  reg        latch_d;

  always @* begin
    st_d    = st_q;
    latch_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (dual) begin
          st_d = tp_on ? ST_TORQUE : ST_WAIT;
        end
      end
      ST_TORQUE: begin
        if (!dual) begin
          st_d = ST_IDLE;
        end else if (!tp_on) begin
          st_d = ST_WAIT; // R3
        end
      end
      ST_WAIT: begin
        if (!dual) begin
          st_d = ST_IDLE;
        end else if (tp_on) begin
          st_d = ST_TORQUE; // R5
        end else if (trig_rise) begin
          st_d    = ST_RUN; // R4
          latch_d = 1'b1;
        end
      end
      ST_RUN: begin
        if (!dual) begin
          st_d = ST_IDLE;
        end else if (tp_on) begin
          st_d = ST_TORQUE; // R5
        end else if (trig_rise) begin
          latch_d = 1'b1; // R4
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // trigger edges while in torque mode fall through without effect
  wire in_torque = (st_d == ST_TORQUE); // R2
  wire in_pos    = (st_d == ST_WAIT) | (st_d == ST_RUN);

  // ==========================================================
  // position command
  reg  [5:0]    pos_idx_q;
  reg  [PW-1:0] pos_cmd_q;
  reg           from_tbl_q;
  reg           move_q;
  reg           hold_q;
  reg           tmode_q;
  reg           pmode_q;
  wire [5:0]    idx_d = latch_d ? pos_sel : pos_idx_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= ST_IDLE;
      pos_idx_q  <= 6'h00;
      pos_cmd_q  <= {PW{1'b0}};
      from_tbl_q <= 1'b0;
      move_q     <= 1'b0;
      hold_q     <= 1'b0;
      tmode_q    <= 1'b0;
      pmode_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      pos_idx_q <= idx_d; // R4
      move_q    <= latch_d; // R4
      hold_q    <= (st_d == ST_WAIT); // R3
      tmode_q   <= in_torque; // R2
      pmode_q   <= in_pos;
      if (latch_d) begin
        from_tbl_q <= pr_mode; // R1
      end
      if (st_d != ST_RUN) begin
        pos_cmd_q <= {PW{1'b0}}; // R3
      end else if (latch_d ? pr_mode : from_tbl_q) begin
        pos_cmd_q <= tbl_mem_q[idx_d]; // R1
      end else begin
        pos_cmd_q <= pulse_position_in; // R1
      end
    end
  end

  // ==========================================================
  // torque command, speed and torque limits
  function [15:0] abs16;
    input signed [15:0] v;
    begin
      abs16 = v[15] ? (16'h0000 - v) : v;
    end
  endfunction

  wire signed [15:0] spd_src = (spd_sel == 2'h0) ? analog_speed_in :
                               $signed(spd_pre_q[spd_sel - 2'h1]); // R7
  wire signed [15:0] trq_src = (tcm_sel == 2'h0) ? analog_torque_in :
                               $signed(trq_pre_q[tcm_sel - 2'h1]); // R9
  wire [15:0] spd_mag  = abs16(spd_src);
  wire [15:0] trq_mag  = abs16(trq_src);
  wire        spd_lim  = in_torque & limit_en_q[`LIM_SPEED_BIT]; // R8
  wire        trq_lim  = in_pos & limit_en_q[`LIM_TORQUE_BIT]; // R10

  reg signed [15:0] trq_cmd_q;
  reg        [15:0] spd_limit_q;
  reg               spd_lim_q;
  reg        [15:0] trq_limit_q;
  reg               trq_lim_q;
  reg               pulse_rev_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trq_cmd_q   <= 16'sh0000;
      spd_limit_q <= `RST_MAX_SPEED;
      spd_lim_q   <= 1'b0;
      trq_limit_q <= 16'h0000;
      trq_lim_q   <= 1'b0;
      pulse_rev_q <= 1'b0;
    end else begin
      trq_cmd_q   <= in_torque ? trq_src : 16'sh0000; // R2
      spd_lim_q   <= spd_lim; // R8
      trq_lim_q   <= trq_lim; // R10
      // the maximum-speed ceiling stands even when the selectable limit is off
      if (spd_lim && (spd_mag < max_speed_q)) begin
        spd_limit_q <= spd_mag; // R7
      end else begin
        spd_limit_q <= max_speed_q; // R6
      end
      trq_limit_q <= trq_lim ? trq_mag : 16'h0000; // R10
      pulse_rev_q <= polarity_q[4]; // R15
    end
  end

  // ==========================================================
  // analog monitor scaling
  function signed [9:0] mon_scale;
    input signed [47:0] q;
    input        [47:0] fs;
    input        [6:0]  prop;
    reg   signed [47:0] num;
    reg   signed [47:0] den;
    reg   signed [47:0] quo;
    begin
      num = q * $signed({41'h0, prop}) * `MON_FULL_CODE;
      den = $signed(fs * `PROP_FULL);
      // a zero full scale would divide by zero; report zero instead
      if (den == 48'sh0) begin
        quo = 48'sh0;
      end else begin
        quo = num / den;
      end
      if (quo > `MON_FULL_CODE) begin
        mon_scale = `MON_POS_SAT;
      end else if (quo < `MON_NEG_CODE) begin
        mon_scale = `MON_NEG_SAT;
      end else begin
        mon_scale = quo[9:0];
      end
    end
  endfunction

  wire signed [47:0] q_spd  = {{(48-QW){motor_speed[QW-1]}}, motor_speed};
  wire signed [47:0] q_trq  = {{(48-QW){motor_torque[QW-1]}}, motor_torque};
  wire signed [47:0] q_pls  = {{(48-QW){pulse_frequency[QW-1]}}, pulse_frequency};
  wire signed [47:0] q_scmd = {{(48-QW){speed_command[QW-1]}}, speed_command};
  wire signed [47:0] q_tcmd = {{(48-QW){torque_command[QW-1]}}, torque_command};
  wire signed [47:0] q_bus  = {{(48-QW){bus_voltage[QW-1]}}, bus_voltage};
  wire        [19:0] mon_w;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_mon
      wire [2:0] digit = (ch == 0) ? mon_src_q[6:4] : mon_src_q[2:0]; // R11
      wire       inv   = (ch == 0) ? polarity_q[1] : polarity_q[0]; // R14
      wire [6:0] prop  = (ch == 0) ? prop1_q : prop2_q; // R16
      reg signed [47:0] q_sel;
      reg        [47:0] fs_sel;
      reg signed [9:0]  code_q;
      wire signed [9:0] scaled = mon_scale(q_sel, fs_sel, prop); // R13

      always @* begin
        case (digit)
          `SRC_SPEED: begin
            q_sel  = q_spd; // R12
            fs_sel = {32'h0, max_speed_q};
          end
          `SRC_TORQUE: begin
            q_sel  = q_trq; // R12
            fs_sel = {24'h0, MAX_TORQUE};
          end
          `SRC_PULSE: begin
            q_sel  = q_pls; // R12
            fs_sel = `PULSE_FS;
          end
          `SRC_SPEED_CMD: begin
            q_sel  = q_scmd; // R12
            fs_sel = {32'h0, max_speed_q};
          end
          `SRC_TORQUE_CMD: begin
            q_sel  = q_tcmd; // R12
            fs_sel = {24'h0, MAX_TORQUE_CMD};
          end
          `SRC_BUS_V: begin
            q_sel  = q_bus; // R12
            fs_sel = `BUS_FS;
          end
          default: begin
            q_sel  = 48'sh0; // R20
            fs_sel = 48'h0;
          end
        endcase
      end

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          code_q <= 10'sh000;
        end else begin
          // saturation keeps the magnitude at 511, so negation never overflows
          code_q <= inv ? (10'sh000 - scaled) : scaled; // R14
        end
      end

      assign mon_w[ch*10 +: 10] = code_q;
    end
  endgenerate

  // ==========================================================
  // register read port: data stands in the cycle after the strobe only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_MON_SRC:   rdata_q <= {9'h000, mon_src_q};
        `OFS_POLARITY:  rdata_q <= {11'h000, polarity_q};
        `OFS_PROP_CH1:  rdata_q <= {9'h000, prop1_q};
        `OFS_PROP_CH2:  rdata_q <= {9'h000, prop2_q};
        `OFS_CTRL_MODE: rdata_q <= {8'h00, ctrl_mode_q};
        `OFS_LIMIT_EN:  rdata_q <= {14'h0000, limit_en_q};
        `OFS_MAX_SPEED: rdata_q <= max_speed_q;
        `OFS_SPD_PRE1:  rdata_q <= spd_pre_q[0];
        `OFS_SPD_PRE2:  rdata_q <= spd_pre_q[1];
        `OFS_SPD_PRE3:  rdata_q <= spd_pre_q[2];
        `OFS_TRQ_PRE1:  rdata_q <= trq_pre_q[0];
        `OFS_TRQ_PRE2:  rdata_q <= trq_pre_q[1];
        `OFS_TRQ_PRE3:  rdata_q <= trq_pre_q[2];
        `OFS_TBL_INDEX: rdata_q <= {10'h000, tbl_index_q};
        `OFS_TBL_LO:    rdata_q <= tbl_mem_q[tbl_index_q][15:0];
        `OFS_TBL_HI:    rdata_q <= tbl_mem_q[tbl_index_q][PW-1:16];
        `OFS_STATUS:    rdata_q <= {pos_idx_q, from_tbl_q, trq_lim_q, spd_lim_q,
                                    hold_q, st_q, pmode_q, tmode_q};
        default:        rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata           = rdata_q;
  assign torque_mode         = tmode_q;
  assign position_mode       = pmode_q;
  assign motor_hold          = hold_q;
  assign move_start          = move_q;
  assign position_cmd        = pos_cmd_q;
  assign position_from_table = from_tbl_q;
  assign torque_cmd          = trq_cmd_q;
  assign speed_limit         = spd_limit_q;
  assign speed_limit_active  = spd_lim_q;
  assign torque_limit        = trq_limit_q;
  assign torque_limit_active = trq_lim_q;
  assign pulse_reverse       = pulse_rev_q;
  assign monitor_channel_one = mon_w[9:0];
  assign monitor_channel_two = mon_w[19:10];

endmodule // servo_mode_limit_monitor_select

`default_nettype wire

// file: servo_select_consts.vh
// constants for the servo mode, limit and monitor selection block
`ifndef SERVO_SELECT_CONSTS_VH
`define SERVO_SELECT_CONSTS_VH

// ==========================================================
// register byte offsets
`define OFS_MON_SRC      16'h0006
`define OFS_POLARITY     16'h0106
`define OFS_PROP_CH1     16'h0108
`define OFS_PROP_CH2     16'h010A
`define OFS_CTRL_MODE    16'h0200
`define OFS_LIMIT_EN     16'h0202
`define OFS_MAX_SPEED    16'h0204
`define OFS_SPD_PRE1     16'h0206
`define OFS_SPD_PRE2     16'h0208
`define OFS_SPD_PRE3     16'h020A
`define OFS_TRQ_PRE1     16'h020C
`define OFS_TRQ_PRE2     16'h020E
`define OFS_TRQ_PRE3     16'h0210
`define OFS_TBL_INDEX    16'h0220
`define OFS_TBL_LO       16'h0222
`define OFS_TBL_HI       16'h0224
`define OFS_STATUS       16'h0230

// ==========================================================
// reset values
`define RST_MON_SRC      7'h01
`define RST_POLARITY     5'h00
`define RST_PROP         7'h64
`define RST_CTRL_MODE    8'h00
`define RST_LIMIT_EN     2'h0
`define RST_MAX_SPEED    16'h0BB8

// ==========================================================
// field layout and codes
`define LIM_SPEED_BIT    0
`define LIM_TORQUE_BIT   1
`define MODE_PT_T        8'h07
`define MODE_PR_T        8'h09
`define PROP_MAX         7'h64
`define SRC_SPEED        3'h0
`define SRC_TORQUE       3'h1
`define SRC_PULSE        3'h2
`define SRC_SPEED_CMD    3'h3
`define SRC_TORQUE_CMD   3'h4
`define SRC_BUS_V        3'h5

// ==========================================================
// monitor scaling: full scale in pps and volts, code for 8 V, percent base
`define PULSE_FS         48'h000000044AA20
`define BUS_FS           48'h0000000001C2
`define MON_FULL_CODE    48'sh0000000001FF
`define MON_NEG_CODE     (-48'sh0000000001FF)
`define MON_POS_SAT      10'sh1FF
`define MON_NEG_SAT      10'sh201
`define PROP_FULL        48'h000000000064

`endif

// file: smlms_props.sv
// assertion checker for the servo mode, limit and monitor selection block
`timescale 1ns/1ps
`default_nettype none
module smlms_checker (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               torque_position_select,
  input wire logic               command_trigger,
  input wire logic               torque_mode,
  input wire logic               position_mode,
  input wire logic               motor_hold,
  input wire logic               move_start,
  input wire logic signed [15:0] torque_cmd,
  input wire logic               speed_limit_active,
  input wire logic               torque_limit_active,
  input wire logic signed [9:0]  monitor_channel_one
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====
  // sequences
  sequence trig_rise;
    $rose(command_trigger) && position_mode && !torque_position_select
      ##1 !torque_position_select [*2];
  endsequence
  sequence tp_fall;
    torque_mode && $fell(torque_position_select) ##1 !torque_position_select [*2];
  endsequence
  sequence tp_rise;
    position_mode && $rose(torque_position_select) ##1 torque_position_select [*2];
  endsequence
  // ====
  // properties
  trig_start_a: assert property (trig_rise |=> move_start)
    else $error("trigger edge gave no move start");
  tp_off_hold_a: assert property (tp_fall |=> motor_hold && position_mode)
    else $error("position entry did not hold the motor");
  tp_on_torque_a: assert property (tp_rise |=> torque_mode)
    else $error("torque mode not restored at once");
  start_pulse_a: assert property (move_start |=> !move_start)
    else $error("move start longer than one cycle");
  start_state_a: assert property (move_start |-> position_mode && !motor_hold)
    else $error("move start outside position run");
  torque_excl_a: assert property (torque_mode |-> !position_mode && !motor_hold)
    else $error("torque and position modes overlap");
  trq_cmd_zero_a: assert property (!torque_mode && !$past(torque_mode) |-> torque_cmd == 0)
    else $error("torque command outside torque mode");
  spd_lim_mode_a: assert property (speed_limit_active |-> torque_mode || $past(torque_mode))
    else $error("speed limit outside torque mode");
  trq_lim_mode_a: assert property
    (torque_limit_active |-> position_mode || $past(position_mode))
    else $error("torque limit outside position mode");
  mon_range_a: assert property (monitor_channel_one != 10'h200)
    else $error("monitor code beyond full scale");
endmodule // smlms_checker
bind servo_mode_limit_monitor_select smlms_checker chk_i (.*);
`default_nettype wire

// file: tb_top.sv
// self-checking testbench for the servo mode, limit and monitor selection block
`include "servo_select_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk, rst_n, reg_wr, reg_rd;
  logic [15:0] reg_addr, reg_wdata, analog_speed_in, analog_torque_in;
  logic [31:0] pulse_position_in;
  logic [23:0] motor_speed, motor_torque, pulse_frequency;
  logic [23:0] speed_command, torque_command, bus_voltage;
  wire  [15:0] reg_rdata, torque_cmd, speed_limit, torque_limit;
  wire  [31:0] position_cmd;
  wire  [9:0]  monitor_channel_one, monitor_channel_two;
  wire         torque_mode, position_mode, motor_hold, move_start, position_from_table;
  wire         speed_limit_active, torque_limit_active, pulse_reverse;
  wire         torque_position_select, command_trigger;
  wire  [1:0]  torque_cmd_select, speed_cmd_select;
  wire  [5:0]  position_cmd_select;
  int          mismatches, checks_done, cycles;

  motion_ctl_model ctl (.*);
  servo_mode_limit_monitor_select uut (.*);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ====
  // shared tasks
  task summarize;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rdc(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({16'h0, reg_rdata}, {16'h0, exp});
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wait_move(input logic exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 10 && !seen; i++) begin
      @(posedge clk);
      #1 seen = (move_start === 1'b1);
    end
    chk({31'h0, seen}, {31'h0, exp});
  endtask
  // ====
  // scenarios
  task t_regs;
    rdc(`OFS_MON_SRC, 16'h0001);
    rdc(`OFS_POLARITY, 16'h0000);
    rdc(`OFS_PROP_CH1, 16'h0064);
    rdc(`OFS_PROP_CH2, 16'h0064);
    rdc(`OFS_MAX_SPEED, 16'h0BB8);
    rdc(16'h0300, 16'h0000);
    wr(`OFS_MON_SRC, 16'h0077);
    rdc(`OFS_MON_SRC, 16'h0077);
    wr(`OFS_PROP_CH1, 16'h00C8);
    rdc(`OFS_PROP_CH1, 16'h0064);
    $display("test regs done");
  endtask
  task t_pulse_dual;
    wr(`OFS_TRQ_PRE1, 16'h0040);
    wr(`OFS_TRQ_PRE3, 16'h0077);
    wr(`OFS_CTRL_MODE, 16'h0007);
    ctl.set_sel(2'h1, 2'h0);
    settle(5);
    chk({31'h0, torque_mode}, 32'h1);
    chk({16'h0, torque_cmd}, 32'h0040);
    wr(`OFS_LIMIT_EN, 16'h0002);
    ctl.set_sel(2'h3, 2'h0);
    ctl.set_tp(1'b0);
    settle(5);
    chk({30'h0, motor_hold, position_mode}, 32'h3);
    chk({16'h0, torque_limit}, 32'h0077);
    chk({31'h0, torque_limit_active}, 32'h1);
    @(posedge clk);
    pulse_position_in <= 32'h12345678;
    ctl.raise_trig(6'h00);
    wait_move(1'b1);
    chk(position_cmd, 32'h12345678);
    chk({31'h0, position_from_table}, 32'h0);
    ctl.drop_trig;
    ctl.set_tp(1'b1);
    settle(4);
    chk({31'h0, torque_mode}, 32'h1);
    chk({31'h0, torque_limit_active}, 32'h0);
    $display("test pulse_dual done");
  endtask
  task t_speed_limit;
    wr(`OFS_SPD_PRE2, 16'h0100);
    ctl.set_sel(2'h0, 2'h2);
    settle(5);
    chk({16'h0, speed_limit}, 32'h0BB8);
    chk({16'h0, torque_cmd}, {16'h0, analog_torque_in});
    wr(`OFS_LIMIT_EN, 16'h0001);
    settle(3);
    chk({16'h0, speed_limit}, 32'h0100);
    chk({31'h0, speed_limit_active}, 32'h1);
    wr(`OFS_SPD_PRE2, 16'h1000);
    settle(3);
    chk({16'h0, speed_limit}, 32'h0BB8);
    $display("test speed_limit done");
  endtask
  task t_table_dual;
    wr(`OFS_CTRL_MODE, 16'h0009);
    wr(`OFS_TBL_INDEX, 16'h0005);
    wr(`OFS_TBL_LO, 16'hBEEF);
    wr(`OFS_TBL_HI, 16'hCAFE);
    ctl.set_tp(1'b0);
    settle(5);
    ctl.raise_trig(6'h05);
    wait_move(1'b1);
    chk(position_cmd, 32'hCAFEBEEF);
    chk({31'h0, position_from_table}, 32'h1);
    ctl.drop_trig;
    ctl.set_tp(1'b1);
    settle(4);
    ctl.raise_trig(6'h05);
    wait_move(1'b0);
    ctl.drop_trig;
    $display("test table_dual done");
  endtask
  task t_monitor;
    @(posedge clk);
    pulse_frequency <= 24'h225510;
    bus_voltage <= 24'h0001C2;
    motor_speed <= 24'h000BB8;
    motor_torque <= 24'hFFFF6A;
    torque_command <= 24'h00012C;
    wr(`OFS_MON_SRC, 16'h0025);
    wr(`OFS_PROP_CH2, 16'h0032);
    wr(`OFS_POLARITY, 16'h0012);
    settle(4);
    chk({22'h0, monitor_channel_one}, 32'h301);
    chk({22'h0, monitor_channel_two}, 32'h0FF);
    chk({31'h0, pulse_reverse}, 32'h1);
    wr(`OFS_MON_SRC, 16'h0060);
    settle(4);
    chk({22'h0, monitor_channel_one}, 32'h0);
    chk({22'h0, monitor_channel_two}, 32'h0FF);
    wr(`OFS_MON_SRC, 16'h0041);
    settle(4);
    chk({22'h0, monitor_channel_one}, 32'h201);
    chk({22'h0, monitor_channel_two}, 32'h381);
    $display("test monitor done");
  endtask
  // ====
  // main sequence and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize;
    end
  end
  initial begin
    {mismatches, checks_done, cycles} = '0;
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {analog_speed_in, pulse_position_in, motor_speed, motor_torque} = '0;
    {pulse_frequency, speed_command, torque_command, bus_voltage} = '0;
    analog_torque_in = 16'h00C8;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_pulse_dual;
    t_speed_limit;
    t_table_dual;
    t_monitor;
    summarize;
  end
endmodule // tb_top
`default_nettype wire
